/* File: rtdseq_pkg.sv */
/*
  Shared constants and types for the resistive temperature discharge sequencer.
  Assumes a 100 MHz system clock and a 4 MHz fast oscillator time base for results.
*/
package rtdseq_pkg;
  // ==========================================================================
  // time base
  localparam int CLK_PERIOD_NS      = 10;
  localparam int FAST_OSC_PERIOD_NS = 250;
  localparam int FRAC_BITS          = 16;
  localparam logic [31:0] LSB_PER_CLK =
    32'((CLK_PERIOD_NS * (1 << FRAC_BITS)) / FAST_OSC_PERIOD_NS);
  localparam int DCH_SHORT_US  = 512;
  localparam int DCH_LONG_US   = 1024;
  localparam int DCH_SHORT_CYC = (DCH_SHORT_US * 1000) / CLK_PERIOD_NS;
  localparam int DCH_LONG_CYC  = (DCH_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int CHARGE_NS     = 1000;
  localparam int CHARGE_CYC    = (CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BASE0_US      = 1000;
  localparam int BASE1_US      = 2000;
  localparam int PAUSE_Q0_CYC  = (BASE0_US * 1000) / (CLK_PERIOD_NS * 4);
  localparam int PAUSE_Q1_CYC  = (BASE1_US * 1000) / (CLK_PERIOD_NS * 4);
  // ==========================================================================
  // sequence shape
  localparam logic [4:0] TWO_WIRE_CYCLES  = 5'd5;
  localparam logic [4:0] FOUR_WIRE_CYCLES = 5'd14;
  localparam logic [4:0] FAKE_FEW         = 5'd2;
  localparam logic [4:0] FAKE_MANY        = 5'd8;
  localparam logic [4:0] RESULTS_PER_MEAS = 5'd5;
  localparam logic [3:0] PAUSE_CODE_MAX   = 4'd9;
  localparam logic [8:0] BUF_BASE_M1      = 9'h080;
  localparam logic [8:0] BUF_BASE_M2      = 9'h085;
  localparam logic [8:0] BUF_LAST         = 9'h089;
  localparam logic [1:0] PORT_COMP        = 2'd0;
  localparam logic [1:0] PORT_REF         = 2'd1;
  localparam logic [1:0] PORT_COLD        = 2'd2;
  localparam logic [1:0] PORT_HOT         = 2'd3;
  localparam logic [4:0] STEP_RA          = 5'd4;
  localparam logic [1:0] REF_INTERNAL     = 2'd0;
  localparam logic [1:0] REF_EXTERNAL     = 2'd1;
  localparam logic [1:0] REF_TOGGLE       = 2'd2;
  localparam logic [1:0] ORDER_DEFAULT    = 2'b00;
  localparam logic [1:0] ORDER_REVERSED   = 2'b01;
  localparam logic [1:0] ORDER_DEF_REV    = 2'b10;
  localparam logic [1:0] ORDER_REV_DEF    = 2'b11;
  // ==========================================================================
  // types
  typedef logic [17:0] rtdseq_cyc_t;
  typedef logic [23:0] rtdseq_pause_t;
  typedef logic [31:0] rtdseq_time_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_CHARGE = 4'h2,
    ST_DISCH  = 4'h4,
    ST_PAUSE  = 4'h8
  } rtdseq_state_e;
endpackage

/* File: rtdseq_dch_timer.sv */
/*
  Discharge timer: times one capacitor discharge in fast oscillator units.
  Assumes the comparator input is already synchronous to sys_clk.
*/
`timescale 1ns/1ns
module rtdseq_dch_timer (
  input  wire logic                 sys_clk,    // system clock
  input  wire logic                 rst_n,      // synchronised reset, active low
  input  wire logic                 clk_en,     // freezes state when low
  input  wire logic                 start,      // begin timing, one cycle
  input  wire logic                 discharged, // comparator: threshold reached
  input  wire rtdseq_pkg::rtdseq_cyc_t limit,   // discharge limit in cycles
  output logic                      done,       // pulse: valid time in value
  output logic                      timeout,    // pulse: limit reached
  output rtdseq_pkg::rtdseq_time_t  value       // 16.16 time result
);
  import rtdseq_pkg::*;

  logic        run_q;
  rtdseq_cyc_t cnt_q;

  // 16.16 fixed point in fast oscillator periods
  function automatic rtdseq_time_t time_of(input rtdseq_cyc_t c);
    time_of = 32'(32'(c) * LSB_PER_CLK);
  endfunction

  wire at_limit_w = ({1'b0, cnt_q} + 19'd1) >= {1'b0, limit};

  // ==========================================================================
  // timing
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      run_q   <= 1'b0;
      cnt_q   <= '0;
      done    <= 1'b0;
      timeout <= 1'b0;
      value   <= '0;
    end
    else if (clk_en)
    begin
      done    <= 1'b0;
      timeout <= 1'b0;
      if (start)
      begin
        run_q <= 1'b1;
        cnt_q <= '0;
      end
      else if (run_q && discharged)
      begin
        run_q <= 1'b0;
        done  <= 1'b1;
        value <= time_of(cnt_q);
      end
      else if (run_q && at_limit_w)
      begin
        run_q   <= 1'b0;
        timeout <= 1'b1;
      end
      else if (run_q)
        cnt_q <= cnt_q + 18'd1;
    end

  // ==========================================================================
  // checks
  limit_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run_q |-> cnt_q < limit) else $error("discharge count passed its limit");
  time_scale_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run_q && discharged && !start && clk_en) |=> done && value == time_of($past(cnt_q)))
    else $error("discharge time not scaled to 16.16 units");
endmodule // rtdseq_dch_timer

/* File: rtdseq_sequencer.sv */
/*
  Temperature measurement sequencer: schedules measurement pairs, drives the sensor
  port switches and writes discharge times into the shared result buffer.
  Assumes all inputs but rst_b are synchronous to sys_clk and settings are steady while busy.
*/
// Behaviour
// - time each capacitor discharge through one sensor port or the reference.
// - two-wire measurement runs five discharge cycles after the dummy cycles.
// - four-wire measurement runs fourteen discharge cycles after the dummy cycles.
// - run two or eight dummy discharges first; never store them.
// - start measurements every 1 to 1023 sequence cycles; a rate of 0 stops them.
// - pause between the two measurements is 0.25 to 2.5 base periods.
// - cycle through two or three sensor ports; third is the hot sensor.
// - wiring select picks the two-wire or four-wire sequence.
// - pull select 0 pulls inactive ports down; 1 leaves them floating.
// - reference internal, external, or alternating between the two measurements.
// - discharge limit is 512 us or 1024 us.
// - port order default, reversed, or swapped between the two measurements.
// - store five results per measurement at 0x080-0x084 and 0x085-0x089.
// - results are 16.16 times in fast oscillator periods.
`timescale 1ns/1ns
module rtdseq_sequencer #(
  parameter rtdseq_pkg::rtdseq_cyc_t   DCH_SHORT_CYC_P = 18'(rtdseq_pkg::DCH_SHORT_CYC),
  parameter rtdseq_pkg::rtdseq_cyc_t   DCH_LONG_CYC_P  = 18'(rtdseq_pkg::DCH_LONG_CYC),
  parameter rtdseq_pkg::rtdseq_pause_t PAUSE_Q0_CYC_P  = 24'(rtdseq_pkg::PAUSE_Q0_CYC),
  parameter rtdseq_pkg::rtdseq_pause_t PAUSE_Q1_CYC_P  = 24'(rtdseq_pkg::PAUSE_Q1_CYC)
) (
  input  wire logic       sys_clk,                 // 100 MHz clock
  input  wire logic       rst_b,                   // async reset, active low
  input  wire logic       clk_en,                  // freezes all state but the reset release when low
  input  wire logic       seq_tick,                // one pulse per sequence cycle
  input  wire logic       usm_busy,                // flight time measurement owns buffer
  input  wire logic       cap_discharged,          // comparator: capacitor discharged
  input  wire logic [9:0] temp_meas_rate,          // sequence cycles per measurement
  input  wire logic [3:0] inter_meas_pause,        // pause code, quarter base periods
  input  wire logic       base_frequency_select,   // base period choice
  input  wire logic       sensor_port_count,       // 0: two ports, 1: three ports
  input  wire logic       sensor_wiring_select,    // 0: two-wire, 1: four-wire
  input  wire logic       dummy_cycle_count,       // 0: two, 1: eight dummies
  input  wire logic       idle_port_pull_select,   // 0: pull idle ports down
  input  wire logic [1:0] reference_source_select, // reference mode
  input  wire logic       discharge_limit_select,  // 0: 512 us, 1: 1024 us
  input  wire logic [1:0] port_sequence_order,     // port order code
  output logic [3:0]      port_en_q,               // discharge switch per port
  output logic [3:0]      port_pulldown_q,         // pull-down per port
  output logic            ref_external_q,          // external reference selected
  output logic            charge_q,                // charging the load capacitor
  output logic            buf_we_q,                // result buffer write strobe
  output logic [8:0]      buf_addr_q,              // result buffer address
  output logic [31:0]     buf_wdata_q,             // result buffer data
  output logic            meas_busy_q,             // measurement pair running
  output logic            meas_done_q,             // pulse: pair finished
  output logic            dch_error_q              // discharge timed out this pair
);
  import rtdseq_pkg::*;

  // ==========================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_s_q;
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_n_s_q  <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_s_q  <= rst_meta_q;
    end

  // ==========================================================================
  // state
  rtdseq_state_e st_q;
  logic          meas_q;
  logic [4:0]    idx_q;
  logic [9:0]    rate_cnt_q;
  logic          pend_q;
  rtdseq_pause_t cnt_q;
  logic          timer_done;
  logic          timer_to;
  rtdseq_time_t  timer_val;

  // real step to port, honouring order and port count
  function automatic logic [1:0] step_port(input logic [4:0] s, input logic rev,
                                           input logic three);
    logic [1:0] last;
    last = three ? PORT_HOT : PORT_COLD;
    case (s)
      5'd0:    step_port = PORT_COMP;
      5'd1:    step_port = rev ? last : PORT_REF;
      5'd2:    step_port = (rev && !three) ? PORT_REF : PORT_COLD;
      5'd3:    step_port = (rev && three) ? PORT_REF : PORT_HOT;
      5'd4:    step_port = PORT_REF;
      default: step_port = three ? 2'(((s - 5'd5) % 5'd3) + 5'd1)
                                 : 2'(((s - 5'd5) % 5'd2) + 5'd1);
    endcase
  endfunction

  function automatic rtdseq_pause_t pause_len(input logic [3:0] code, input logic bf);
    logic [3:0] c;
    c = (code > PAUSE_CODE_MAX) ? PAUSE_CODE_MAX : code;
    pause_len = 24'((24'(c) + 24'd1) * (bf ? PAUSE_Q1_CYC_P : PAUSE_Q0_CYC_P));
  endfunction

  // ==========================================================================
  // decoding
  wire [4:0] nfake_w   = dummy_cycle_count ? FAKE_MANY : FAKE_FEW;
  wire [4:0] nreal_w   = sensor_wiring_select ? FOUR_WIRE_CYCLES : TWO_WIRE_CYCLES;
  wire [4:0] total_w   = nfake_w + nreal_w;
  wire       is_real_w = idx_q >= nfake_w;
  wire [4:0] step_w    = idx_q - nfake_w;
  wire       rev_w     = (port_sequence_order == ORDER_REVERSED) ||
                         (port_sequence_order == ORDER_DEF_REV && meas_q) ||
                         (port_sequence_order == ORDER_REV_DEF && !meas_q);
  wire [1:0] sport_w   = step_port(step_w, rev_w, sensor_port_count);
  wire [1:0] dport_w   = is_real_w ? sport_w : PORT_REF;
  wire       skip_w    = is_real_w && !sensor_port_count && step_w == 5'd3;
  wire [2:0] slot_w    = (step_w == STEP_RA) ? 3'(STEP_RA) : {1'b0, sport_w};
  wire       store_w   = is_real_w && step_w < RESULTS_PER_MEAS;
  wire [8:0] addr_w    = (meas_q ? BUF_BASE_M2 : BUF_BASE_M1) + {6'd0, slot_w};
  wire       last_w    = idx_q == total_w - 5'd1;
  wire       rate_on_w = temp_meas_rate != 10'd0;
  wire       rate_hit_w = seq_tick && rate_on_w &&
                          ({1'b0, rate_cnt_q} + 11'd1) >= {1'b0, temp_meas_rate};
  wire       start_go_w = st_q == ST_IDLE && pend_q && rate_on_w && !usm_busy;
  wire       chg_end_w  = st_q == ST_CHARGE && cnt_q == 24'd0;
  wire       dch_end_w  = st_q == ST_DISCH && (timer_done || timer_to);
  wire       step_end_w = dch_end_w || (chg_end_w && skip_w);
  wire       pause_end_w = st_q == ST_PAUSE && cnt_q == 24'd0;
  wire       ref_m1_w   = reference_source_select == REF_EXTERNAL;
  wire       ref_m2_w   = ref_m1_w || reference_source_select == REF_TOGGLE;
  wire       timer_go_w = chg_end_w && !skip_w && clk_en;
  wire rtdseq_cyc_t limit_w = discharge_limit_select ? DCH_LONG_CYC_P : DCH_SHORT_CYC_P;
  wire [3:0] port_en_d  = timer_go_w ? (4'd1 << dport_w)
                        : (dch_end_w ? 4'd0 : port_en_q);
  wire       busy_d     = st_q != ST_IDLE || start_go_w;

  // ==========================================================================
  // scheduling
  always_ff @(posedge sys_clk or negedge rst_n_s_q)
    if (!rst_n_s_q)
    begin
      rate_cnt_q <= '0;
      pend_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!rate_on_w || rate_hit_w)
        rate_cnt_q <= '0;
      else if (seq_tick)
        rate_cnt_q <= rate_cnt_q + 10'd1;
      pend_q <= rate_on_w && ((pend_q && !start_go_w) || rate_hit_w);
    end

  // ==========================================================================
  // sequence control
  always_ff @(posedge sys_clk or negedge rst_n_s_q)
    if (!rst_n_s_q)
    begin
      st_q   <= ST_IDLE;
      meas_q <= 1'b0;
      idx_q  <= '0;
      cnt_q  <= '0;
    end
    else if (clk_en)
    begin
      case (st_q)
        ST_IDLE:
          if (start_go_w)
          begin
            st_q   <= ST_CHARGE;
            meas_q <= 1'b0;
            idx_q  <= '0;
            cnt_q  <= 24'(CHARGE_CYC - 1);
          end
        ST_CHARGE:
          if (chg_end_w && !skip_w)
            st_q <= ST_DISCH;
          else if (!chg_end_w)
            cnt_q <= cnt_q - 24'd1;
        ST_PAUSE:
          if (pause_end_w)
          begin
            st_q   <= ST_CHARGE;
            meas_q <= 1'b1;
            idx_q  <= '0;
            cnt_q  <= 24'(CHARGE_CYC - 1);
          end
          else
            cnt_q <= cnt_q - 24'd1;
        default: ;
      endcase
      // step advance shared by discharge end and skipped hot step
      if (clk_en && step_end_w)
      begin
        if (!last_w)
        begin
          st_q  <= ST_CHARGE;
          idx_q <= idx_q + 5'd1;
          cnt_q <= 24'(CHARGE_CYC - 1);
        end
        else if (!meas_q)
        begin
          st_q  <= ST_PAUSE;
          cnt_q <= pause_len(inter_meas_pause, base_frequency_select) - 24'd1;
        end
        else
          st_q <= ST_IDLE;
      end
    end

  // ==========================================================================
  // discharge timing
  rtdseq_dch_timer i_timer (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n_s_q),
    .clk_en     (clk_en),
    .start      (timer_go_w),
    .discharged (cap_discharged),
    .limit      (limit_w),
    .done       (timer_done),
    .timeout    (timer_to),
    .value      (timer_val)
  );

  // ==========================================================================
  // output decoding
  wire       wr_time_w  = dch_end_w && timer_done && store_w;
  // skipped hot slot gets a zero word so stale flight time data never reads as a result
  wire       wr_blank_w = chg_end_w && skip_w && store_w;
  wire       wr_any_w   = wr_time_w || wr_blank_w;
  wire       pull_on_w  = !idle_port_pull_select && port_en_d != 4'h0;
  wire [3:0] pulldown_d = pull_on_w ? ~port_en_d : 4'h0;
  wire       ref_d      = meas_q ? ref_m2_w : ref_m1_w;
  wire       charge_d   = st_q == ST_CHARGE && !chg_end_w;
  wire       done_d     = step_end_w && last_w && meas_q;
  // a timeout in the same cycle as a new start still wins
  wire       err_d      = (dch_end_w && timer_to) || (dch_error_q && !start_go_w);

  // ==========================================================================
  // registered outputs
  always_ff @(posedge sys_clk or negedge rst_n_s_q)
    if (!rst_n_s_q)
    begin
      port_en_q       <= '0;
      port_pulldown_q <= '0;
      ref_external_q  <= 1'b0;
      charge_q        <= 1'b0;
      buf_we_q        <= 1'b0;
      buf_addr_q      <= '0;
      buf_wdata_q     <= '0;
      meas_busy_q     <= 1'b0;
      meas_done_q     <= 1'b0;
      dch_error_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      port_en_q       <= port_en_d;
      port_pulldown_q <= pulldown_d;
      ref_external_q  <= ref_d;
      charge_q        <= charge_d;
      buf_we_q        <= wr_any_w;
      meas_busy_q     <= busy_d;
      meas_done_q     <= done_d;
      dch_error_q     <= err_d;
      if (wr_any_w)
      begin
        buf_addr_q  <= addr_w;
        buf_wdata_q <= wr_time_w ? timer_val : 32'h0;
      end
    end

  // ==========================================================================
  // checks
  fake_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    (clk_en && dch_end_w && !is_real_w) |=> !buf_we_q)
    else $error("dummy discharge was stored");
  addr_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    buf_we_q |-> (buf_addr_q >= BUF_BASE_M1 && buf_addr_q <= BUF_LAST))
    else $error("result written outside the temperature slots");
  idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    (st_q == ST_IDLE && (!rate_on_w || usm_busy)) |=> st_q == ST_IDLE)
    else $error("measurement started while disabled or blocked");
  timeout_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    (clk_en && dch_end_w && timer_to) |=> (!buf_we_q && dch_error_q))
    else $error("timed out discharge stored or not flagged");
  one_port_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    $onehot0(port_en_q))
    else $error("more than one discharge path enabled");
  pause_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n_s_q)
    (clk_en && pause_end_w) |=> (st_q == ST_CHARGE && meas_q))
    else $error("pause did not lead into the second measurement");

  pair_done_c: cover property (@(posedge sys_clk) meas_done_q && !dch_error_q);
  pair_error_c: cover property (@(posedge sys_clk) meas_done_q && dch_error_q);
  blank_slot_c: cover property (@(posedge sys_clk) wr_blank_w);
  second_ext_c: cover property (@(posedge sys_clk) meas_q && ref_external_q && port_en_q != 4'h0);
endmodule // rtdseq_sequencer

/* File: rtdseq_cap_model.sv */
/*
  Load capacitor, sensors and reference resistor seen by the sequencer.
  Assumes port_en and charge come straight from the sequencer outputs.
*/
`timescale 1ns/1ns
module rtdseq_cap_model (
  input  wire logic       sys_clk, // 100 MHz clock
  input  wire logic [3:0] port_en, // discharge switch per port
  input  wire logic       charge,  // capacitor being charged
  input  wire logic       slow,    // every discharge takes 300 cycles
  output logic            cap_low  // comparator: threshold reached
);
  int cnt = 0;
  int lim;
  // ==========================================================================
  // discharge time grows with the port index, so slots can be told apart
  assign lim = slow ? 300 : port_en[3] ? 70 : port_en[2] ? 60 : port_en[1] ? 50 : 40;
  initial cap_low = 1'b0;
  always @(posedge sys_clk)
  begin
    if (charge)
    begin
      cnt <= 0;
      cap_low <= 1'b0;
    end
    else if (port_en != 4'h0 && !cap_low)
    begin
      cnt <= cnt + 1;
      cap_low <= (cnt + 1 >= lim);
    end
  end
endmodule // rtdseq_cap_model

/* File: tb_top.sv */
/*
  Self-checking bench for the temperature discharge sequencer.
  Assumes the capacitor model answers on port_en and charge; limits are shortened.
*/
`timescale 1ns/1ns
module tb_top;
  import rtdseq_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, seq_tick = 1'b0, usm_busy = 1'b0;
  logic cap_discharged, slow = 1'b0;
  logic [9:0] temp_meas_rate = 10'h0;
  logic [3:0] inter_meas_pause = 4'h0;
  logic base_frequency_select = 1'b0, sensor_port_count = 1'b0, sensor_wiring_select = 1'b0;
  logic dummy_cycle_count = 1'b0, idle_port_pull_select = 1'b0, discharge_limit_select = 1'b0;
  logic [1:0] reference_source_select = 2'h0, port_sequence_order = 2'h0;
  logic [3:0] port_en_q, port_pulldown_q;
  logic ref_external_q, charge_q, buf_we_q, meas_busy_q, meas_done_q, dch_error_q;
  logic [8:0] buf_addr_q;
  logic [31:0] buf_wdata_q;
  logic [8:0] wr_addr[$];
  logic [31:0] wr_data[$];
  logic chg_prev = 1'b0, err_done;
  int n_chg, ref_hi, ref_lo, hot_seen, pd_bad, busy_seen, tick_cnt = 0;
  int err_total = 0, compares = 0;
  // ==========================================================================
  // clock, sequence tick and design
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    tick_cnt <= (tick_cnt == 199) ? 0 : tick_cnt + 1;
    #1 seq_tick = (tick_cnt == 0);
  end
  rtdseq_sequencer #(.DCH_SHORT_CYC_P(18'h000c8), .DCH_LONG_CYC_P(18'h00190),
    .PAUSE_Q0_CYC_P(24'h000014), .PAUSE_Q1_CYC_P(24'h000028)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .seq_tick(seq_tick),
    .usm_busy(usm_busy), .cap_discharged(cap_discharged), .temp_meas_rate(temp_meas_rate),
    .inter_meas_pause(inter_meas_pause), .base_frequency_select(base_frequency_select),
    .sensor_port_count(sensor_port_count), .sensor_wiring_select(sensor_wiring_select),
    .dummy_cycle_count(dummy_cycle_count), .idle_port_pull_select(idle_port_pull_select),
    .reference_source_select(reference_source_select),
    .discharge_limit_select(discharge_limit_select), .port_sequence_order(port_sequence_order),
    .port_en_q(port_en_q), .port_pulldown_q(port_pulldown_q), .ref_external_q(ref_external_q),
    .charge_q(charge_q), .buf_we_q(buf_we_q), .buf_addr_q(buf_addr_q),
    .buf_wdata_q(buf_wdata_q), .meas_busy_q(meas_busy_q), .meas_done_q(meas_done_q),
    .dch_error_q(dch_error_q));
  rtdseq_cap_model i_cap (.sys_clk(sys_clk), .port_en(port_en_q), .charge(charge_q),
    .slow(slow), .cap_low(cap_discharged));
  // ==========================================================================
  // monitor: results are fetched as they are written, before any flight time run
  always @(posedge sys_clk)
  begin
    if (buf_we_q === 1'b1)
    begin
      wr_addr.push_back(buf_addr_q);
      wr_data.push_back(buf_wdata_q);
    end
    if (charge_q === 1'b1 && chg_prev !== 1'b1)
      n_chg++;
    chg_prev = charge_q;
    busy_seen |= (meas_busy_q === 1'b1);
    if (port_en_q !== 4'h0)
    begin
      ref_hi |= (ref_external_q === 1'b1);
      ref_lo |= (ref_external_q === 1'b0);
      hot_seen |= (port_en_q[PORT_HOT] === 1'b1);
      pd_bad |= (port_pulldown_q !== (idle_port_pull_select ? 4'h0 : ~port_en_q));
    end
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic setup(input logic w, f, ports, pull, input logic [1:0] rsel, ord);
    wr_addr.delete();
    wr_data.delete();
    {n_chg, ref_hi, ref_lo, hot_seen, pd_bad, busy_seen} = '0;
    {sensor_wiring_select, dummy_cycle_count, sensor_port_count} = {w, f, ports};
    {idle_port_pull_select, reference_source_select, port_sequence_order} = {pull, rsel, ord};
    temp_meas_rate = 10'h001;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 40000 && meas_done_q !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    err_done = dch_error_q;
    temp_meas_rate = 10'h000;
    if (i == 40000)
    begin
      $display("[FAIL] meas_done_q expected 1 seen 0");
      err_total++;
      summarize();
    end
    else
    begin
      repeat (4) @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_two_wire;
    setup(1'b0, 1'b0, 1'b1, 1'b0, REF_INTERNAL, ORDER_DEFAULT);
    wait_done();
    chk("write count", 32'd10, 32'(wr_addr.size()));
    for (int i = 0; i < 10; i++)
      chk("write addr", 32'(BUF_BASE_M1) + 32'(i), 32'(wr_addr[i]));
    chk("discharges", 32'd14, 32'(n_chg));
    chk("hot port used", 32'd1, 32'(hot_seen));
    chk("external ref", 32'd0, 32'(ref_hi));
    chk("idle pull", 32'd0, 32'(pd_bad));
    chk("cold minus ref", 32'd10 * LSB_PER_CLK, wr_data[2] - wr_data[1]);
    chk("error flag", 32'd0, 32'(err_done));
  endtask
  task automatic t_toggle_reversed;
    setup(1'b0, 1'b1, 1'b0, 1'b1, REF_TOGGLE, ORDER_REVERSED);
    base_frequency_select = 1'b1;
    inter_meas_pause = PAUSE_CODE_MAX;
    wait_done();
    chk("write count", 32'd10, 32'(wr_addr.size()));
    chk("discharges", 32'd26, 32'(n_chg));
    chk("hot port used", 32'd0, 32'(hot_seen));
    chk("both refs", 32'd2, 32'(ref_hi + ref_lo));
    chk("idle pull", 32'd0, 32'(pd_bad));
    chk("cold2 minus ref2", 32'd10 * LSB_PER_CLK, wr_data[6] - wr_data[7]);
  endtask
  task automatic t_four_wire;
    setup(1'b1, 1'b0, 1'b1, 1'b0, REF_EXTERNAL, ORDER_DEF_REV);
    wait_done();
    chk("discharges", 32'd32, 32'(n_chg));
    chk("write count", 32'd10, 32'(wr_addr.size()));
    chk("internal ref", 32'd0, 32'(ref_lo));
    chk("idle pull", 32'd0, 32'(pd_bad));
  endtask
  task automatic t_limit;
    slow = 1'b1;
    setup(1'b0, 1'b0, 1'b0, 1'b0, REF_INTERNAL, ORDER_REV_DEF);
    discharge_limit_select = 1'b0;
    wait_done();
    chk("short limit error", 32'd1, 32'(err_done));
    setup(1'b0, 1'b0, 1'b0, 1'b0, REF_INTERNAL, ORDER_REV_DEF);
    discharge_limit_select = 1'b1;
    wait_done();
    chk("long limit error", 32'd0, 32'(err_done));
    chk("write count", 32'd10, 32'(wr_addr.size()));
    slow = 1'b0;
  endtask
  task automatic t_blocked;
    busy_seen = 0;
    repeat (1000) @(posedge sys_clk);
    #1;
    chk("busy at rate zero", 32'd0, 32'(busy_seen));
    usm_busy = 1'b1;
    setup(1'b0, 1'b0, 1'b0, 1'b0, REF_INTERNAL, ORDER_DEFAULT);
    repeat (1000) @(posedge sys_clk);
    #1;
    chk("busy under flight run", 32'd0, 32'(busy_seen));
    usm_busy = 1'b0;
    wait_done();
    chk("write count", 32'd10, 32'(wr_addr.size()));
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_two_wire();
    t_toggle_reversed();
    t_four_wire();
    t_limit();
    t_blocked();
    summarize();
  end
endmodule // tb_top
